/* File: verilog/lsl_pkg.sv */
// constants shared by the serial segment loader and its helpers
// assumes a single 50 MHz bus clock; all link pins arrive asynchronously
`default_nettype none
package lsl_pkg;
	localparam int unsigned CLK_HZ          = 50_000_000;
	localparam int unsigned FRAME_HZ_DUAL   = 75;
	localparam int unsigned FRAME_HZ_SINGLE = 35;
	// dual: one tick per backplane phase; single: one tick per frame
	localparam int unsigned TICK_CYC_DUAL   = CLK_HZ / (FRAME_HZ_DUAL * 2);
	localparam int unsigned TICK_CYC_SINGLE = CLK_HZ / FRAME_HZ_SINGLE;
	localparam int unsigned WORD_SHORT      = 22;
	localparam int unsigned WORD_LONG       = 34;
	localparam int unsigned CNT_W           = 6;
	localparam int unsigned REG_ADDR_W      = 8;
	localparam logic [7:0]  REG_CTRL        = 8'h00;
	localparam logic [7:0]  REG_STATUS      = 8'h04;
	localparam logic [7:0]  REG_LATCH_A     = 8'h08;
	localparam logic [7:0]  REG_LATCH_B     = 8'h0c;
	localparam int unsigned CTRL_DISP_BIT   = 0;
	localparam int unsigned CTRL_CLEAR_BIT  = 1;
	localparam logic        CTRL_DISP_RST   = 1'b1;
	localparam int unsigned ST_OK_BIT       = 0;
	localparam int unsigned ST_LEAD_BIT     = 1;
	localparam int unsigned ST_COUNT_BIT    = 2;
	localparam int unsigned ST_DIST_BIT     = 3;
	localparam int unsigned ST_SLAVE_BIT    = 4;
	localparam int unsigned ST_DROP_BIT     = 5;
	localparam int unsigned ST_CNT_LSB      = 8;
	localparam logic [1:0]  HRESP_OKAY      = 2'h0;
	typedef enum logic [0:0] {
		LSL_RX_IDLE  = 1'b0,
		LSL_RX_SHIFT = 1'b1
	} lsl_rx_t;
endpackage : lsl_pkg
`default_nettype wire

/* File: verilog/lsl_sync2.sv */
// two-flop synchroniser for a bundle of asynchronous levels
// assumes each bit is an independent level; no bus coherence is implied
`default_nettype none
module lsl_sync2 #(
	parameter int unsigned  W   = 1,
	// reset value should match each pin's idle level, so no false edge follows reset
	parameter logic [W-1:0] RST = '0
) (
	input  wire logic         hclk,
	input  wire logic         hresetn,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] meta_q;
	logic [W-1:0] meta_d;
	logic [W-1:0] sync_d;

	always_comb begin
		meta_d = din;
		sync_d = meta_q;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meta_q <= RST;
			dout   <= RST;
		end else begin
			meta_q <= meta_d;
			dout   <= sync_d;
		end
	end
endmodule : lsl_sync2
`default_nettype wire

/* File: verilog/lsl_frame_gen.sv */
// backplane phase and polarity timer built from the internal clock
// assumes run is low whenever backplane timing comes from another device
`default_nettype none
module lsl_frame_gen #(
	parameter int unsigned TICK_CYCLES = lsl_pkg::TICK_CYC_DUAL,
	parameter bit          SINGLE_BP   = 1'b0
) (
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic run,
	output logic      phase_q,
	output logic      pol_q
);
	localparam int unsigned CW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
	localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);
	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;
	logic          phase_d;
	logic          pol_d;

	always_comb begin
		cnt_d   = cnt_q;
		phase_d = phase_q;
		pol_d   = pol_q;
		if (!run) begin
			cnt_d = '0;
		end else if (cnt_q == LAST) begin
			cnt_d = '0;
			// polarity flips once per full frame so the glass sees no dc
			if (SINGLE_BP || phase_q) begin
				pol_d = !pol_q;
			end
			phase_d = SINGLE_BP ? 1'b0 : !phase_q;
		end else begin
			cnt_d = cnt_q + CW'(1);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q   <= '0;
			phase_q <= 1'b0;
			pol_q   <= 1'b0;
		end else begin
			cnt_q   <= cnt_d;
			phase_q <= phase_d;
			pol_q   <= pol_d;
		end
	end
endmodule : lsl_frame_gen
`default_nettype wire

/* File: verilog/lsl_loader.sv */
// serial segment loader: three-line word receiver, display latches,
// backplane/segment drive and an ahb-lite register slave
// assumes link pins are asynchronous to hclk and far slower than it
// Contract
// RQ1: high word bit turns its segment on
// RQ2: word length is 22 or 34 bits
// RQ3: 40, 64 or 32 segments, own latches
// RQ4: dual backplane 1:2, single backplane 1:1
// RQ5: 22-bit: bit 21 selects latch set
// RQ6: 22-bit: pulse 23 loads the latches
// RQ7: 34-bit dual: bit 33 selects latch set
// RQ8: 34-bit: pulse 35 loads the latches
// RQ9: single backplane loads only when bit 33 high
// RQ10: first bit must be zero, else invalid
// RQ11: wrong bit count makes the word invalid
// RQ12: line disturbance during shifting makes word invalid
// RQ13: invalid word leaves all latches unchanged
// RQ14: load is pulse with enable low; then ready
// RQ15: oscillator pin low makes backplanes timing inputs
// RQ16: single variant masters only single-variant slaves
// RQ17: reset clears shift register, counter and latches
// RQ18: enable high over word; sample on rising clock
// RQ19: waveform polarity inverts every frame
// RQ20: single variant, bit 33 low discards word
//
// The address map and register access over AHB-Lite were chosen for this implementation.
`default_nettype none
module lsl_loader #(
	parameter int unsigned WORD_BITS   = lsl_pkg::WORD_LONG,
	parameter bit          SINGLE_BP   = 1'b0,
	parameter int unsigned TICK_CYCLES = SINGLE_BP ? lsl_pkg::TICK_CYC_SINGLE : lsl_pkg::TICK_CYC_DUAL,
	localparam int unsigned SEG        = WORD_BITS - 2
) (
	input  wire logic            hclk,
	input  wire logic            hresetn,
	input  wire logic            hsel,
	input  wire logic [31:0]     haddr,
	input  wire logic [1:0]      htrans,
	input  wire logic            hwrite,
	input  wire logic [2:0]      hsize,
	input  wire logic            hready,
	input  wire logic [31:0]     hwdata,
	output logic      [31:0]     hrdata,
	output logic                 hreadyout,
	output logic      [1:0]      hresp,
	input  wire logic            burst_clock_in,
	input  wire logic            line_enable_in,
	input  wire logic            data_in,
	input  wire logic            osc_in,
	input  wire logic            backplane_first_i,
	output logic                 backplane_first_o,
	output logic                 backplane_first_oe,
	input  wire logic            backplane_second_i,
	output logic                 backplane_second_o,
	output logic                 backplane_second_oe,
	output logic      [SEG-1:0]  segment_outputs
);
	localparam int unsigned     CW       = lsl_pkg::CNT_W;
	localparam logic [CW-1:0]   WORD_CNT = CW'(WORD_BITS); // RQ2
	localparam logic [CW-1:0]   CNT_MAX  = '1;

	// all six link-side levels pass two flops before anything reads them
	// the oscillator pin idles high: a zero reset value would fake slave mode after reset
	localparam logic [5:0] PIN_IDLE = 6'h04;
	logic [5:0] pins_s;
	logic       bclk_s;
	logic       en_s;
	logic       data_s;
	logic       osc_s;
	logic       bp1_s;
	logic       bp2_s;

	lsl_sync2 #(
		.W   (6),
		.RST (PIN_IDLE)
	) u_sync (
		.hclk    (hclk),
		.hresetn (hresetn),
		.din     ({burst_clock_in, line_enable_in, data_in, osc_in, backplane_first_i, backplane_second_i}),
		.dout    (pins_s)
	);
	assign {bclk_s, en_s, data_s, osc_s, bp1_s, bp2_s} = pins_s;

	// ---------------- edge detection on synchronised levels
	logic bclk_p_q;
	logic en_p_q;
	logic data_p_q;
	logic bclk_rise;
	logic en_rise;
	logic en_fall;
	logic data_chg;
	logic load_cond;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bclk_p_q <= 1'b0;
			en_p_q   <= 1'b0;
			data_p_q <= 1'b0;
		end else begin
			bclk_p_q <= bclk_s;
			en_p_q   <= en_s;
			data_p_q <= data_s;
		end
	end

	always_comb begin
		bclk_rise = bclk_s && !bclk_p_q;
		en_rise   = en_s && !en_p_q;
		en_fall   = !en_s && en_p_q;
		data_chg  = data_s != data_p_q;
		load_cond = bclk_rise && !en_s; // RQ14
	end

	// ---------------- word receiver
	lsl_pkg::lsl_rx_t         rx_q;
	lsl_pkg::lsl_rx_t         rx_d;
	logic [WORD_BITS-1:0]     sreg_q;
	logic [WORD_BITS-1:0]     sreg_d;
	logic [CW-1:0]            cnt_q;
	logic [CW-1:0]            cnt_d;
	logic                     dist_q;
	logic                     dist_d;
	logic                     lead_q;
	logic                     lead_d;

	always_comb begin
		rx_d   = rx_q;
		sreg_d = sreg_q;
		cnt_d  = cnt_q;
		dist_d = dist_q;
		lead_d = lead_q;
		if (load_cond) begin
			// valid or not, the receiver is clean for the next word
			rx_d   = lsl_pkg::LSL_RX_IDLE; // RQ14
			cnt_d  = '0;
			dist_d = 1'b0;
			lead_d = 1'b0;
		end else begin
			case (rx_q)
				lsl_pkg::LSL_RX_IDLE: begin
					if (en_rise) begin
						// a new word drops any unfinished one
						rx_d   = lsl_pkg::LSL_RX_SHIFT;
						cnt_d  = '0;
						dist_d = 1'b0;
						lead_d = 1'b0;
					end
				end
				lsl_pkg::LSL_RX_SHIFT: begin
					if (bclk_rise) begin
						sreg_d = {data_s, sreg_q[WORD_BITS-1:1]}; // RQ18
						if (cnt_q == '0) begin
							// kept apart: a short or long word leaves another bit at position 0
							lead_d = data_s; // RQ10
						end
						cnt_d  = (cnt_q == CNT_MAX) ? cnt_q : cnt_q + CW'(1); // RQ11
					end
					// data must hold while the clock is high; enable must drop with clock low
					if (bclk_s && bclk_p_q && (data_chg || en_fall)) begin
						dist_d = 1'b1; // RQ12
					end
					if (en_fall) begin
						rx_d = lsl_pkg::LSL_RX_IDLE;
					end
				end
				default: begin
					rx_d = lsl_pkg::LSL_RX_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_q   <= lsl_pkg::LSL_RX_IDLE; // RQ17
			sreg_q <= '0;
			cnt_q  <= '0;
			dist_q <= 1'b0;
			lead_q <= 1'b0;
		end else begin
			rx_q   <= rx_d;
			sreg_q <= sreg_d;
			cnt_q  <= cnt_d;
			dist_q <= dist_d;
			lead_q <= lead_d;
		end
	end

	// ---------------- word checks and latch transfer
	logic           lead_err;
	logic           cnt_err;
	logic           word_ok;
	logic           sel_first;
	logic [SEG-1:0] payload;
	logic           load_a;
	logic           load_b;
	logic           drop;

	always_comb begin
		lead_err  = lead_q; // RQ10
		cnt_err   = cnt_q != WORD_CNT; // RQ11
		word_ok   = !lead_err && !cnt_err && !dist_q; // RQ13
		sel_first = sreg_q[WORD_BITS-1]; // RQ5 RQ7 RQ9
		payload   = sreg_q[WORD_BITS-2:1];
		load_a    = load_cond && word_ok && sel_first; // RQ6 RQ8
		load_b    = load_cond && word_ok && !sel_first && !SINGLE_BP;
		drop      = load_cond && word_ok && !sel_first && SINGLE_BP; // RQ20
	end

	logic [SEG-1:0] latch_a_q;
	logic [SEG-1:0] latch_a_d;
	logic [SEG-1:0] latch_b_q;
	logic [SEG-1:0] latch_b_d;
	logic           clear_req;

	always_comb begin
		latch_a_d = latch_a_q;
		latch_b_d = latch_b_q;
		if (clear_req) begin
			latch_a_d = '0;
			latch_b_d = '0;
		end
		// a word landing with a software clear still wins
		if (load_a) begin
			latch_a_d = payload; // RQ1 RQ3
		end
		if (load_b) begin
			latch_b_d = payload;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			latch_a_q <= '0; // RQ17
			latch_b_q <= '0;
		end else begin
			latch_a_q <= latch_a_d;
			latch_b_q <= latch_b_d;
		end
	end

	// result of the most recent load condition, for software
	logic [5:0] last_q;
	logic [5:0] last_d;

	always_comb begin
		last_d = last_q;
		if (load_cond) begin
			last_d = {2'h0, dist_q, cnt_err, lead_err, word_ok};
			last_d[lsl_pkg::ST_DROP_BIT] = drop;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			last_q <= '0;
		end else begin
			last_q <= last_d;
		end
	end

	// ---------------- backplane timing: own timer or another device's pins
	logic slave_q;
	logic slave_d;
	logic gen_phase;
	logic gen_pol;
	logic phase_cur;
	logic pol_cur;

	assign slave_d = !osc_s; // RQ15

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			slave_q <= 1'b0;
		end else begin
			slave_q <= slave_d;
		end
	end

	lsl_frame_gen #(
		.TICK_CYCLES (TICK_CYCLES),
		.SINGLE_BP   (SINGLE_BP)
	) u_frame (
		.hclk    (hclk),
		.hresetn (hresetn),
		.run     (!slave_q),
		.phase_q (gen_phase),
		.pol_q   (gen_pol)
	);

	always_comb begin
		phase_cur = gen_phase;
		pol_cur   = gen_pol;
		if (slave_q) begin
			// recover the master's phase from its two backplanes; a single build takes polarity from the first alone
			pol_cur   = SINGLE_BP ? bp1_s : bp2_s; // RQ15 RQ16
			phase_cur = SINGLE_BP ? 1'b0 : (bp1_s ^ bp2_s);
		end
	end

	logic           ctrl_disp_q;
	logic [SEG-1:0] seg_on;
	logic [SEG-1:0] seg_q;
	logic [SEG-1:0] seg_d;
	logic           bp1_q;
	logic           bp1_d;
	logic           bp2_q;
	logic           bp2_d;

	genvar gi;
	generate
		for (gi = 0; gi < SEG; gi++) begin : g_seg
			assign seg_on[gi] = ctrl_disp_q && ((phase_cur && !SINGLE_BP) ? latch_b_q[gi] : latch_a_q[gi]); // RQ4
		end
	endgenerate

	always_comb begin
		// active backplane sits at pol; an on segment sits opposite it
		seg_d = seg_on ^ {SEG{pol_cur}}; // RQ1 RQ19
		bp1_d = SINGLE_BP ? pol_cur : (pol_cur ^ phase_cur); // RQ4
		bp2_d = pol_cur;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			seg_q <= '0;
			bp1_q <= 1'b0;
			bp2_q <= 1'b0;
		end else begin
			seg_q <= seg_d;
			bp1_q <= bp1_d;
			bp2_q <= bp2_d;
		end
	end

	assign segment_outputs     = seg_q;
	assign backplane_first_o   = bp1_q;
	assign backplane_second_o  = bp2_q;
	assign backplane_first_oe  = !slave_q; // RQ15
	assign backplane_second_oe = !slave_q && !SINGLE_BP;

	// ---------------- ahb-lite register slave, zero wait states
	logic                         ap_valid;
	logic                         wr_pend_q;
	logic                         wr_pend_d;
	logic [lsl_pkg::REG_ADDR_W-1:0] wr_addr_q;
	logic [lsl_pkg::REG_ADDR_W-1:0] wr_addr_d;
	logic [31:0]                  rdata_q;
	logic [31:0]                  rdata_d;
	logic [31:0]                  status;
	logic                         ctrl_disp_d;

	always_comb begin
		status = '0;
		status[lsl_pkg::ST_DROP_BIT:lsl_pkg::ST_OK_BIT] = last_q;
		status[lsl_pkg::ST_SLAVE_BIT] = slave_q;
		status[lsl_pkg::ST_CNT_LSB +: CW] = cnt_q;
		ap_valid  = hsel && hready && htrans[1];
		wr_pend_d = ap_valid && hwrite;
		wr_addr_d = ap_valid ? haddr[lsl_pkg::REG_ADDR_W-1:0] : wr_addr_q;
		rdata_d   = rdata_q;
		if (ap_valid && !hwrite) begin
			case (haddr[lsl_pkg::REG_ADDR_W-1:0])
				lsl_pkg::REG_CTRL:    rdata_d = 32'(ctrl_disp_q);
				lsl_pkg::REG_STATUS:  rdata_d = status;
				lsl_pkg::REG_LATCH_A: rdata_d = 32'(latch_a_q);
				lsl_pkg::REG_LATCH_B: rdata_d = SINGLE_BP ? 32'h0000_0000 : 32'(latch_b_q);
				default:              rdata_d = 32'h0000_0000;
			endcase
		end
		ctrl_disp_d = ctrl_disp_q;
		clear_req   = 1'b0;
		if (wr_pend_q && (wr_addr_q == lsl_pkg::REG_CTRL)) begin
			ctrl_disp_d = hwdata[lsl_pkg::CTRL_DISP_BIT];
			clear_req   = hwdata[lsl_pkg::CTRL_CLEAR_BIT];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q   <= 1'b0;
			wr_addr_q   <= '0;
			rdata_q     <= '0;
			ctrl_disp_q <= lsl_pkg::CTRL_DISP_RST;
		end else begin
			wr_pend_q   <= wr_pend_d;
			wr_addr_q   <= wr_addr_d;
			rdata_q     <= rdata_d;
			ctrl_disp_q <= ctrl_disp_d;
		end
	end

	assign hrdata    = rdata_q;
	assign hreadyout = 1'b1;
	assign hresp     = lsl_pkg::HRESP_OKAY;

	// ---------------- checks
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	load_first_a: assert property (load_a |=> latch_a_q == $past(payload)) else $error("first latch not loaded"); // RQ5
	load_second_a: assert property (load_b |=> latch_b_q == $past(payload)) else $error("second latch not loaded"); // RQ7
	lead_zero_a: assert property (load_cond && lead_q && !clear_req // RQ10
		|=> $stable(latch_a_q) && $stable(latch_b_q)) else $error("word with leading one was loaded");
	bit_count_a: assert property (load_cond && (cnt_q != WORD_CNT) && !clear_req // RQ11
		|=> $stable(latch_a_q) && $stable(latch_b_q)) else $error("word of wrong length was loaded");
	disturb_drop_a: assert property (load_cond && dist_q && !clear_req // RQ12
		|=> $stable(latch_a_q) && $stable(latch_b_q)) else $error("disturbed word was loaded");
	ready_again_a: assert property (load_cond |=> (cnt_q == '0) && !dist_q && (rx_q == lsl_pkg::LSL_RX_IDLE)) // RQ14
		else $error("receiver not ready after load");
	single_gate_a: assert property (SINGLE_BP && load_cond && !sreg_q[WORD_BITS-1] && !clear_req // RQ20
		|=> $stable(latch_a_q)) else $error("single variant loaded with select low");
	slave_pins_a: assert property (!osc_s |=> !backplane_first_oe && !backplane_second_oe) // RQ15
		else $error("backplane driven in slave mode");
	seg_level_a: assert property (##1 ctrl_disp_q && !slave_q && $stable(pol_cur) && !phase_cur // RQ1
		|=> segment_outputs[0] == ($past(latch_a_q[0]) ^ bp2_q)) else $error("segment level wrong");
	reset_clear_a: assert property ($rose(hresetn) |-> (latch_a_q == '0) && (latch_b_q == '0) && (cnt_q == '0)) // RQ17
		else $error("state not cleared by reset");

	good_load_c: cover property (load_a);
	bad_load_c: cover property (load_cond && !word_ok);
	slave_run_c: cover property (slave_q && $changed(pol_cur));
endmodule : lsl_loader
`default_nettype wire

/* File: testbench/lsl_link_model.sv */
// link-side partner: a controller that shifts words into the loader
// assumes the loader samples these pins asynchronously; 160 ns bit period
`default_nettype none
module lsl_link_model (
	output logic link_clk,
	output logic link_en,
	output logic link_dat
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		link_clk = 1'b0;
		link_en  = 1'b0;
		link_dat = 1'b1;
	end
	// glitch flips data while the clock is high on bit 5, the only line disturbance the model can make
	// the 5 ns offset keeps every pin change off the loader's clock edges
	task automatic send(input logic [33:0] w, input int n, input bit glitch);
		begin
			#5 link_en = 1'b1;
			for (int k = 0; k < n; k++) begin
				link_dat = w[k];
				#60 link_clk = 1'b1;
				if (glitch && k == 5) begin
					#30 link_dat = ~link_dat;
					#30;
				end else begin
					#60;
				end
				link_clk = 1'b0;
				#40;
			end
			link_en = 1'b0;
			// no pull on the data line, so it must not keep showing the last bit
			link_dat = ~link_dat;
			#60 link_clk = 1'b1;
			#60 link_clk = 1'b0;
			#40;
		end
	endtask : send
endmodule : lsl_link_model
`default_nettype wire

/* File: testbench/tb_top.sv */
// self-checking bench for the serial segment loader, 22-bit dual build
// assumes the link model drives the link pins on its own unrelated timing
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int W = 22;
	localparam int S = W - 2;
	typedef struct {logic [33:0] w; int n; logic [5:0] st;} lsl_row_t;
	logic         hclk, hresetn, hsel, hwrite, hreadyout, osc_in, bp1_drv, bp2_drv;
	logic [31:0]  haddr, hwdata, hrdata, rd;
	logic [1:0]   htrans, hresp;
	logic [2:0]   hsize;
	logic         clk_l, en_l, dat_l, bp1_i, bp1_o, bp1_oe, bp2_i, bp2_o, bp2_oe;
	logic [S-1:0] seg, exp_a, exp_b;
	int           n_errors, tests_run;
	lsl_row_t     rows [6];

	assign bp1_i = bp1_oe ? bp1_o : bp1_drv;
	assign bp2_i = bp2_oe ? bp2_o : bp2_drv;

	lsl_link_model u_mcu (.link_clk(clk_l), .link_en(en_l), .link_dat(dat_l));

	lsl_loader #(.WORD_BITS(W), .SINGLE_BP(1'b0), .TICK_CYCLES(8)) u_dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .burst_clock_in(clk_l), .line_enable_in(en_l),
		.data_in(dat_l), .osc_in(osc_in), .backplane_first_i(bp1_i), .backplane_first_o(bp1_o),
		.backplane_first_oe(bp1_oe), .backplane_second_i(bp2_i), .backplane_second_o(bp2_o),
		.backplane_second_oe(bp2_oe), .segment_outputs(seg));

	initial begin
		hclk = 1'b0;
		forever #10 hclk = ~hclk;
	end

	initial begin
		#1ms;
		n_errors++;
		close_out();
	end

	function automatic logic [33:0] mkw(input logic sel, input logic [19:0] p, input logic lead);
		return {12'h0, sel, p, lead};
	endfunction : mkw

	task automatic close_out;
		begin
			$display("checks %0d errors %0d", tests_run, n_errors);
			if (n_errors == 0 && tests_run > 0)
				$display("DONE - PASS");
			else
				$display("DONE - FAIL");
			$finish;
		end
	endtask : close_out

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		begin
			tests_run++;
			if (got !== exp) begin
				n_errors++;
				$display("BAD %0t got %h want %h", $time, got, exp);
			end
		end
	endtask : chk

	task automatic wait_rdy;
		int i;
		begin
			i = 0;
			@(posedge hclk);
			while (hreadyout !== 1'b1 && i < 50) begin
				i++;
				@(posedge hclk);
			end
			if (i >= 50) begin
				n_errors++;
				close_out();
			end
		end
	endtask : wait_rdy

	// one single word transfer; read data is taken at the data-phase end edge
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		begin
			@(posedge hclk);
			hsel   <= 1'b1;
			htrans <= 2'h2;
			haddr  <= {24'h0, a};
			hwrite <= wr;
			hsize  <= 3'h2;
			wait_rdy();
			hsel   <= 1'b0;
			htrans <= 2'h0;
			hwdata <= wd;
			wait_rdy();
			rd = hrdata;
		end
	endtask : ahb

	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		begin
			ahb(1'b0, a, 32'h0);
			chk(rd, e);
			chk({30'h0, hresp}, {30'h0, lsl_pkg::HRESP_OKAY});
		end
	endtask : rchk

	// waits for two equal backplane samples so the segments have caught up
	task automatic seg_chk;
		logic [1:0] b;
		begin
			b = 2'h3;
			for (int i = 0; i < 20; i++) begin
				@(negedge hclk);
				if ({bp1_o, bp2_o} === b)
					break;
				b = {bp1_o, bp2_o};
			end
			chk({12'h0, seg}, {12'h0, ((b[1] ^ b[0]) ? exp_b : exp_a) ^ {S{b[0]}}});
		end
	endtask : seg_chk

	task automatic lat_chk;
		begin
			rchk(lsl_pkg::REG_LATCH_A, {12'h0, exp_a});
			rchk(lsl_pkg::REG_LATCH_B, {12'h0, exp_b});
			seg_chk();
		end
	endtask : lat_chk

	task automatic check_all(input logic [5:0] st);
		begin
			repeat (4) @(posedge hclk);
			ahb(1'b0, lsl_pkg::REG_STATUS, 32'h0);
			chk({26'h0, rd[5:0]}, {26'h0, st});
			lat_chk();
		end
	endtask : check_all

	initial begin
		logic b;
		int   k;
		hresetn = 1'b0;
		hsel    = 1'b0;
		haddr   = 32'h0;
		htrans  = 2'h0;
		hwrite  = 1'b0;
		hsize   = 3'h2;
		hwdata  = 32'h0;
		osc_in  = 1'b1;
		bp1_drv = 1'b1;
		bp2_drv = 1'b0;
		exp_a   = '0;
		exp_b   = '0;
		rows[0] = '{mkw(1'b1, 20'h5a5c3, 1'b0), 22, 6'h01};
		rows[1] = '{mkw(1'b0, 20'h3c0f1, 1'b0), 22, 6'h01};
		rows[2] = '{mkw(1'b1, 20'h0ffff, 1'b1), 22, 6'h02};
		rows[3] = '{mkw(1'b1, 20'h12345, 1'b0), 21, 6'h04};
		rows[4] = '{mkw(1'b0, 20'h12345, 1'b0), 23, 6'h04};
		rows[5] = '{mkw(1'b0, 20'hfffff, 1'b0), 22, 6'h01};
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (4) @(posedge hclk);
		rchk(lsl_pkg::REG_CTRL, 32'h1);
		lat_chk();
		for (int r = 0; r < 6; r++) begin
			u_mcu.send(rows[r].w, rows[r].n, 1'b0);
			if (rows[r].st == 6'h01 && rows[r].w[W-1])
				exp_a = rows[r].w[S:1];
			else if (rows[r].st == 6'h01)
				exp_b = rows[r].w[S:1];
			check_all(rows[r].st);
		end
		// a glitch on the data line mid-word must leave the latches alone
		u_mcu.send(mkw(1'b1, 20'h0f0f0, 1'b0), 22, 1'b1);
		check_all(6'h08);
		ahb(1'b1, lsl_pkg::REG_STATUS, 32'hffffffff);
		rchk(lsl_pkg::REG_STATUS, 32'h8);
		rchk(8'h10, 32'h0);
		b = bp2_o;
		k = 0;
		while (bp2_o === b && k < 40) begin
			@(negedge hclk);
			k++;
		end
		chk({31'h0, bp2_o}, {31'h0, ~b});
		@(posedge hclk);
		osc_in <= 1'b0;
		repeat (8) @(posedge hclk);
		chk({30'h0, bp1_oe, bp2_oe}, 32'h0);
		chk({12'h0, seg}, {12'h0, exp_b});
		ahb(1'b0, lsl_pkg::REG_STATUS, 32'h0);
		chk({31'h0, rd[4]}, 32'h1);
		osc_in <= 1'b1;
		ahb(1'b1, lsl_pkg::REG_CTRL, 32'h3);
		exp_a = '0;
		exp_b = '0;
		rchk(lsl_pkg::REG_CTRL, 32'h1);
		lat_chk();
		u_mcu.send(mkw(1'b1, 20'habcde, 1'b0), 22, 1'b0);
		exp_a = 20'habcde;
		check_all(6'h01);
		// display off: every segment sits at the second backplane's level, so the glass sees nothing
		ahb(1'b1, lsl_pkg::REG_CTRL, 32'h0);
		rchk(lsl_pkg::REG_CTRL, 32'h0);
		@(negedge hclk);
		chk({12'h0, seg}, {12'h0, {S{bp2_o}}});
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (4) @(posedge hclk);
		exp_a = '0;
		rchk(lsl_pkg::REG_CTRL, 32'h1);
		check_all(6'h00);
		close_out();
	end
endmodule : tb_top
`default_nettype wire
